/* File: rtl/accdet_pkg.sv */
`default_nettype none
package accdet_pkg;
	// Register offsets
	localparam logic [7:0] OFS_JACK_STS   = 8'hc0;
	localparam logic [7:0] OFS_BTN_STS    = 8'hc1;
	localparam logic [7:0] OFS_JACK_EVT   = 8'hc2;
	localparam logic [7:0] OFS_BTN_EVT    = 8'hc3;
	localparam logic [7:0] OFS_JACK_MASK  = 8'hc4;
	localparam logic [7:0] OFS_BTN_MASK   = 8'hc5;
	localparam logic [7:0] OFS_CFG_MAIN   = 8'hc6;
	localparam logic [7:0] OFS_CFG_TIMING = 8'hc7;
	localparam logic [7:0] OFS_THR_AD     = 8'hc8;
	localparam logic [7:0] OFS_THR_DB     = 8'hc9;
	localparam logic [7:0] OFS_THR_BC     = 8'hca;
	localparam logic [7:0] OFS_THR_CM     = 8'hcb;
	localparam logic [7:0] OFS_FORCE_AVG  = 8'hcc;
	localparam logic [7:0] OFS_HPTEST     = 8'hcd;
	// Reset values
	localparam logic [7:0] CFG_MAIN_RST   = 8'hd6;
	localparam logic [7:0] CFG_TIMING_RST = 8'h34;
	localparam logic [7:0] THR_AD_RST     = 8'h0a;
	localparam logic [7:0] THR_DB_RST     = 8'h16;
	localparam logic [7:0] THR_BC_RST     = 8'h21;
	localparam logic [7:0] THR_CM_RST     = 8'h3e;
	localparam logic [7:0] FORCE_AVG_RST  = 8'h01;
	// Field positions and write masks
	localparam int unsigned FLAG_W         = 8;
	localparam int unsigned EVT_INSERT_BIT = 0;
	localparam int unsigned EVT_REMOVE_BIT = 1;
	localparam int unsigned EVT_DONE_BIT   = 2;
	localparam int unsigned CFG_EN_BIT     = 0;
	localparam int unsigned CFG_BTN_LSB    = 1;
	localparam int unsigned CFG_BTN_MSB    = 3;
	localparam int unsigned CFG_KIND_BIT   = 6;
	localparam int unsigned CFG_ORDER_BIT  = 7;
	localparam int unsigned TIM_PAUSE_BIT  = 0;
	localparam int unsigned FRC_ORDER_BIT  = 4;
	localparam int unsigned FRC_KIND_BIT   = 5;
	localparam logic [7:0] JACK_FLAG_MASK = 8'h07;
	localparam logic [7:0] FORCE_WR_MASK  = 8'h3f;
	localparam logic [2:0] BTN_OFF        = 3'h0;
	// Timing
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned NS_PER_MS         = 1000000;
	localparam int unsigned CYCLES_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned BTN_INTERVAL_MS [0:7] =
		'{0, 2, 5, 10, 50, 100, 200, 500};
	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_DETECT  = 2'b01,
		SEQ_PRESENT = 2'b11
	} jack_seq_t;
endpackage : accdet_pkg
`default_nettype wire

/* File: rtl/flag_bank_if.sv */
`default_nettype none
interface flag_bank_if import accdet_pkg::*; ();
	logic [FLAG_W-1:0] set;
	logic [FLAG_W-1:0] clr;
	logic [FLAG_W-1:0] flags;
	modport owner (input set, input clr, output flags);
	modport user (output set, output clr, input flags);
endinterface : flag_bank_if
`default_nettype wire

/* File: rtl/event_flag_bank.sv */
`default_nettype none
module event_flag_bank import accdet_pkg::*; (
	input  wire logic  ref_clk,
	input  wire logic  reset,
	flag_bank_if.owner bank
);
	typedef struct packed {
		logic [FLAG_W-1:0] flags;
	} bank_state_t;
	bank_state_t q;
	bank_state_t d;

	always_comb begin
		d = q;
		// R12: set beats write-one clear
		d.flags = (q.flags & ~bank.clr) | bank.set;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bank.flags = q.flags;

	a_set_wins: assert property ( // R12
		@(posedge ref_clk) disable iff (reset)
		(bank.set != '0)
		|=> ((bank.flags & $past(bank.set)) == $past(bank.set)))
		else $error("event flag lost its set");
	a_clear_only_w1c: assert property ( // R12
		@(posedge ref_clk) disable iff (reset)
		(bank.clr == '0)
		|=> ((bank.flags & $past(bank.flags)) == $past(bank.flags)))
		else $error("event flag dropped without a one written");
endmodule : event_flag_bank
`default_nettype wire

/* File: rtl/interval_timer.sv */
`default_nettype none
module interval_timer (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        run,
	input  wire logic [31:0] period,
	output var  logic        tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} timer_state_t;
	timer_state_t q;
	timer_state_t d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!run) begin
			d.cnt = '0;
		end else if (q.cnt >= period - 32'd1) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 32'd1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

	a_tick_needs_run: assert property ( // R17
		@(posedge ref_clk) disable iff (reset)
		tick |-> $past(run))
		else $error("measurement tick while stopped");
	a_tick_spacing: assert property ( // R18
		@(posedge ref_clk) disable iff (reset)
		(tick && run && period > 32'd1) |=> !tick)
		else $error("measurement ticks closer than the period");
	c_tick_seen: cover property (@(posedge ref_clk) disable iff (reset) tick);
endmodule : interval_timer
`default_nettype wire

/* File: rtl/accessory_detect_status_irq.sv */
`default_nettype none
// Function
// R1: Status bit 0 shows jack present
// R2: Status bit 1 shows four-contact kind
// R3: Status bit 2 shows four-contact pin order
// R4: Software ignores kind/order before completion
// R5: Bit 3 mic supply, auto-on four-contact
// R6: Second status holds last button code
// R7: Insertion sets jack event bit 0
// R8: Removal sets jack event bit 1
// R9: Detection end sets jack event bit 2
// R10: Presses A..D set button bits 0..3
// R11: Releases D..A set button bits 4..7
// R12: Flags clear only by writing one
// R13: One mask bit per event, one masks
// R14: Jack masks at bits 0, 1, 2
// R15: Button masks match button event bits
// R16: Enable bit off stops jack events
// R17: Pause stops button checks, not jack
// R18: Interval field selects button period
// R19: Kind detect or forced kind used
// R20: Interrupt when unmasked flag set
module accessory_detect_status_irq import accdet_pkg::*; #(
	parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output var  logic [7:0] reg_rdata,
	input  wire logic       jack_present,
	input  wire logic       detect_done,
	input  wire logic       detected_kind,
	input  wire logic       detected_order,
	input  wire logic       button_code_valid,
	input  wire logic [7:0] button_code,
	input  wire logic [3:0] button_press,
	input  wire logic [3:0] button_release,
	input  wire logic       hptest_comp,
	output var  logic       irq,
	output var  logic       micbias_en,
	output var  logic       kind_detect_req,
	output var  logic       button_measure_req,
	output var  logic [7:0] cfg_main,
	output var  logic [7:0] cfg_timing,
	output var  logic [7:0] thr_a_d,
	output var  logic [7:0] thr_d_b,
	output var  logic [7:0] thr_b_c,
	output var  logic [7:0] thr_c_mic,
	output var  logic [7:0] force_avg,
	output var  logic [2:0] hptest_ctrl
);
	typedef struct packed {
		jack_seq_t  seq;
		logic       present;
		logic       kind;
		logic       order;
		logic       micbias;
		logic       kind_req;
		logic       irq;
		logic [7:0] btn_code;
		logic [7:0] jmask;
		logic [7:0] bmask;
		logic [7:0] cfg_main;
		logic [7:0] cfg_timing;
		logic [7:0] thr_ad;
		logic [7:0] thr_db;
		logic [7:0] thr_bc;
		logic [7:0] thr_cm;
		logic [7:0] force_avg;
		logic [2:0] hptest;
		logic [7:0] rdata;
	} main_state_t;

	main_state_t       q;
	main_state_t       d;
	logic [FLAG_W-1:0] jack_set;
	logic [FLAG_W-1:0] btn_set;
	logic [7:0]        rd_mux;
	logic              en;
	logic              pause;
	logic              kind_det_en;
	logic              order_det_en;
	logic              force_kind;
	logic              force_order;
	logic [2:0]        btn_sel;
	logic              btn_active;
	logic              timer_run;
	logic [31:0]       period;

	flag_bank_if jack_if ();
	flag_bank_if btn_if ();

	assign en           = q.cfg_main[CFG_EN_BIT];
	assign pause        = q.cfg_timing[TIM_PAUSE_BIT];
	assign kind_det_en  = q.cfg_main[CFG_KIND_BIT];
	assign order_det_en = q.cfg_main[CFG_ORDER_BIT];
	assign force_kind   = q.force_avg[FRC_KIND_BIT];
	assign force_order  = q.force_avg[FRC_ORDER_BIT];
	assign btn_sel      = q.cfg_main[CFG_BTN_MSB:CFG_BTN_LSB];

	// R17: checking runs only while not paused
	assign btn_active = (q.seq == SEQ_PRESENT) && q.kind && en && !pause;
	// R18: zero interval stops the checks
	assign timer_run = btn_active && (btn_sel != BTN_OFF);
	assign period = 32'(BTN_INTERVAL_MS[btn_sel] * CYCLES_PER_MS);

	interval_timer u_btn_timer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.run     (timer_run),
		.period  (period),
		.tick    (button_measure_req)
	);

	// R10: press A..D onto bits 0..3
	// R11: release A lands on bit 7
	assign btn_set = btn_active ? {button_release[0], button_release[1],
		button_release[2], button_release[3], button_press} : '0;

	assign jack_if.set = jack_set;
	assign btn_if.set  = btn_set;
	// R12: only written ones acknowledge
	assign jack_if.clr = (reg_wr && reg_addr == OFS_JACK_EVT) ?
		(reg_wdata & JACK_FLAG_MASK) : '0;
	assign btn_if.clr = (reg_wr && reg_addr == OFS_BTN_EVT) ? reg_wdata : '0;

	event_flag_bank u_jack_flags (
		.ref_clk (ref_clk),
		.reset   (reset),
		.bank    (jack_if.owner)
	);

	event_flag_bank u_btn_flags (
		.ref_clk (ref_clk),
		.reset   (reset),
		.bank    (btn_if.owner)
	);

	// Read data; unmapped offsets return zero
	always_comb begin
		case (reg_addr)
			// R1: present, R2: kind, R3: order, R5: supply
			OFS_JACK_STS:   rd_mux = {4'h0, q.micbias, q.order, q.kind,
				q.present};
			// R6: last button code
			OFS_BTN_STS:    rd_mux = q.btn_code;
			OFS_JACK_EVT:   rd_mux = jack_if.flags;
			OFS_BTN_EVT:    rd_mux = btn_if.flags;
			OFS_JACK_MASK:  rd_mux = q.jmask;
			OFS_BTN_MASK:   rd_mux = q.bmask;
			OFS_CFG_MAIN:   rd_mux = q.cfg_main;
			OFS_CFG_TIMING: rd_mux = q.cfg_timing;
			OFS_THR_AD:     rd_mux = q.thr_ad;
			OFS_THR_DB:     rd_mux = q.thr_db;
			OFS_THR_BC:     rd_mux = q.thr_bc;
			OFS_THR_CM:     rd_mux = q.thr_cm;
			OFS_FORCE_AVG:  rd_mux = q.force_avg;
			OFS_HPTEST:     rd_mux = {3'h0, hptest_comp, 1'b0, q.hptest};
			default:        rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		d = q;
		d.kind_req = 1'b0;
		jack_set = '0;
		if (!en) begin
			// R16: disabled, no jack tracking or events
			d.seq = SEQ_IDLE;
			d.present = 1'b0;
			d.kind = 1'b0;
			d.order = 1'b0;
			d.micbias = 1'b0;
		end else if (q.seq != SEQ_IDLE && !jack_present) begin
			// R8: removal flag and status cleared
			jack_set[EVT_REMOVE_BIT] = 1'b1;
			d.seq = SEQ_IDLE;
			d.present = 1'b0;
			d.kind = 1'b0;
			d.order = 1'b0;
			d.micbias = 1'b0;
		end else begin
			case (q.seq)
				SEQ_IDLE: begin
					if (jack_present) begin
						// R7: insertion flag and presence
						jack_set[EVT_INSERT_BIT] = 1'b1;
						d.present = 1'b1;
						// R19: measured or forced kind
						if (kind_det_en) begin
							d.kind_req = 1'b1;
							d.seq = SEQ_DETECT;
						end else begin
							d.kind = force_kind;
							d.order = force_kind & force_order;
							d.micbias = force_kind;
							jack_set[EVT_DONE_BIT] = 1'b1;
							d.seq = SEQ_PRESENT;
						end
					end
				end
				SEQ_DETECT: begin
					if (detect_done) begin
						// R9: completion flag with kind and order
						jack_set[EVT_DONE_BIT] = 1'b1;
						d.kind = detected_kind;
						d.order = detected_kind & (order_det_en ?
							detected_order : force_order);
						// R5: supply on for four-contact
						d.micbias = detected_kind;
						d.seq = SEQ_PRESENT;
					end
				end
				SEQ_PRESENT: d.seq = SEQ_PRESENT;
				default: d.seq = SEQ_IDLE;
			endcase
		end
		// R6: capture newest button code
		if (en && button_code_valid) begin
			d.btn_code = button_code;
		end
		if (reg_wr) begin
			case (reg_addr)
				// R14: jack masks at bits 2:0
				OFS_JACK_MASK:  d.jmask = reg_wdata & JACK_FLAG_MASK;
				// R15: button masks share event layout
				OFS_BTN_MASK:   d.bmask = reg_wdata;
				OFS_CFG_MAIN:   d.cfg_main = reg_wdata;
				OFS_CFG_TIMING: d.cfg_timing = reg_wdata;
				OFS_THR_AD:     d.thr_ad = reg_wdata;
				OFS_THR_DB:     d.thr_db = reg_wdata;
				OFS_THR_BC:     d.thr_bc = reg_wdata;
				OFS_THR_CM:     d.thr_cm = reg_wdata;
				OFS_FORCE_AVG:  d.force_avg = reg_wdata & FORCE_WR_MASK;
				OFS_HPTEST:     d.hptest = reg_wdata[2:0];
				default:        d.hptest = q.hptest;
			endcase
		end
		if (reg_rd) begin
			d.rdata = rd_mux;
		end
		// R13: masked events raise nothing
		// R20: any unmasked flag raises the request
		d.irq = (|(jack_if.flags & ~q.jmask)) || (|(btn_if.flags & ~q.bmask));
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.seq <= SEQ_IDLE;
			q.cfg_main <= CFG_MAIN_RST;
			q.cfg_timing <= CFG_TIMING_RST;
			q.thr_ad <= THR_AD_RST;
			q.thr_db <= THR_DB_RST;
			q.thr_bc <= THR_BC_RST;
			q.thr_cm <= THR_CM_RST;
			q.force_avg <= FORCE_AVG_RST;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata       = q.rdata;
	assign irq             = q.irq;
	assign micbias_en      = q.micbias;
	assign kind_detect_req = q.kind_req;
	assign cfg_main        = q.cfg_main;
	assign cfg_timing      = q.cfg_timing;
	assign thr_a_d         = q.thr_ad;
	assign thr_d_b         = q.thr_db;
	assign thr_b_c         = q.thr_bc;
	assign thr_c_mic       = q.thr_cm;
	assign force_avg       = q.force_avg;
	assign hptest_ctrl     = q.hptest;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_insert_status: assert property ( // R1
		(q.seq == SEQ_IDLE && en && jack_present && !reg_wr)
		|=> (q.present && jack_if.flags[EVT_INSERT_BIT]))
		else $error("insertion not reported");
	a_remove_flag: assert property ( // R8
		(q.seq != SEQ_IDLE && en && !jack_present && !reg_wr)
		|=> (!q.present && jack_if.flags[EVT_REMOVE_BIT]))
		else $error("removal not reported");
	a_detect_done: assert property ( // R9
		(q.seq == SEQ_DETECT && en && jack_present && detect_done && !reg_wr)
		|=> (jack_if.flags[EVT_DONE_BIT] && q.kind == $past(detected_kind)
		&& q.micbias == $past(detected_kind)))
		else $error("detection completion not captured");
	a_order_three: assert property ( // R3
		!q.kind |-> !q.order)
		else $error("pin order set for three-contact jack");
	a_forced_kind: assert property ( // R19
		(q.seq == SEQ_IDLE && en && jack_present && !kind_det_en && !reg_wr)
		|=> (q.kind == $past(force_kind) && q.seq == SEQ_PRESENT))
		else $error("forced kind not applied");
	a_disabled_quiet: assert property ( // R16
		!en |-> (jack_set == '0) ##1 (q.seq == SEQ_IDLE))
		else $error("jack event while detection disabled");
	a_pause_no_req: assert property ( // R17
		pause |=> !button_measure_req)
		else $error("button check while paused");
	a_code_capture: assert property ( // R6
		(en && button_code_valid) |=> (q.btn_code == $past(button_code)))
		else $error("button code not captured");
	a_press_map: assert property ( // R10
		(btn_active && button_press[3]) |=> btn_if.flags[3])
		else $error("button D press not flagged");
	a_release_map: assert property ( // R11
		(btn_active && button_release[0]) |=> btn_if.flags[7])
		else $error("button A release not flagged");
	a_irq_raise: assert property ( // R20
		((btn_if.flags & ~q.bmask) != '0) |=> irq)
		else $error("unmasked flag gave no interrupt");
	a_irq_masked: assert property ( // R13
		((jack_if.flags & ~q.jmask) == '0 && (btn_if.flags & ~q.bmask) == '0)
		|=> !irq)
		else $error("interrupt from masked flags");
	a_irq_jack: assert property ( // R20
		((jack_if.flags & ~q.jmask) != '0) |=> irq)
		else $error("unmasked jack flag gave no interrupt");
	a_supply_kind: assert property ( // R5
		q.micbias == q.kind)
		else $error("mic supply does not follow jack kind");
	a_press_a_map: assert property ( // R10
		(btn_active && button_press[0]) |=> btn_if.flags[0])
		else $error("button A press not flagged");
	a_mask_write: assert property ( // R15
		(reg_wr && reg_addr == OFS_BTN_MASK) |=> (q.bmask == $past(reg_wdata)))
		else $error("button mask write lost");
	a_jack_reserved: assert property ( // R14
		(jack_if.flags & ~JACK_FLAG_MASK) == '0
		&& (q.jmask & ~JACK_FLAG_MASK) == '0)
		else $error("reserved jack bit set");

	c_four_contact: cover property (q.seq == SEQ_DETECT ##[1:20]
		(q.seq == SEQ_PRESENT && q.kind));
	c_button_press: cover property (btn_active && button_press != 4'h0);
	c_irq_ack: cover property (irq ##[1:10] !irq);
endmodule : accessory_detect_status_irq
`default_nettype wire

/* File: verif/test_accessory_detect_status_irq.sv */
`default_nettype none
module test_accessory_detect_status_irq import accdet_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic       ref_clk, reset, reg_wr, reg_rd, jack_present, detect_done;
	logic       detected_kind, detected_order, button_code_valid;
	logic       hptest_comp, irq, micbias_en, kind_detect_req;
	logic       button_measure_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, button_code;
	logic [3:0] button_press, button_release;
	logic [7:0] cfg_main, cfg_timing, thr_a_d, thr_d_b, thr_b_c;
	logic [7:0] thr_c_mic, force_avg;
	logic [2:0] hptest_ctrl;
	// Bench model of flags, masks and status
	logic [7:0] ea, eb, ma, mb, st, code, r, a;
	logic [31:0] seed;
	int         mismatches, comparisons, n;

	accessory_detect_status_irq #(
		.CYCLES_PER_MS(10)
	) i_accessory_detect_status_irq (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .jack_present(jack_present),
		.detect_done(detect_done), .detected_kind(detected_kind),
		.detected_order(detected_order),
		.button_code_valid(button_code_valid), .button_code(button_code),
		.button_press(button_press), .button_release(button_release),
		.hptest_comp(hptest_comp), .irq(irq), .micbias_en(micbias_en),
		.kind_detect_req(kind_detect_req),
		.button_measure_req(button_measure_req), .cfg_main(cfg_main),
		.cfg_timing(cfg_timing), .thr_a_d(thr_a_d), .thr_d_b(thr_d_b),
		.thr_b_c(thr_b_c), .thr_c_mic(thr_c_mic), .force_avg(force_avg),
		.hptest_ctrl(hptest_ctrl)
	);

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic exp_irq();
		return |({ea, eb} & ~{ma, mb});
	endfunction : exp_irq

	task automatic rnd();
		seed = lfsr_next(seed);
		r = seed[7:0];
	endtask : rnd

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= ad;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk8(reg_rdata, exp);
	endtask : rd_chk

	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : step

	task automatic wait_pulse(input logic measure, input int lim);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while ((measure ? button_measure_req : kind_detect_req) !== 1'b1
			&& n < lim);
	endtask : wait_pulse

	task automatic jack(input logic v);
		@(posedge ref_clk);
		jack_present <= v;
	endtask : jack

	task automatic summarize();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	initial begin
		#100000;
		chk1(1'b0, 1'b1);
		summarize();
	end

	initial begin
		logic [7:0] ofs [16];
		logic [7:0] rst [16];
		seed = 32'heaefcbf3;
		{reset, reg_wr, reg_rd, jack_present, detect_done} = 5'h10;
		{detected_kind, detected_order, button_code_valid} = 3'h0;
		{reg_addr, reg_wdata, button_code} = 24'h0;
		{button_press, button_release} = 8'h0;
		hptest_comp = seed[0];
		{ea, eb, ma, mb, st, code} = 48'h0;
		step(10);
		reset <= 1'b0;
		ofs = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
			8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hbf, 8'hd0};
		rst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, CFG_MAIN_RST,
			CFG_TIMING_RST, THR_AD_RST, THR_DB_RST, THR_BC_RST, THR_CM_RST,
			FORCE_AVG_RST, {3'h0, seed[0], 4'h0}, 8'h00, 8'h00};
		for (int i = 0; i < 16; i++)
			rd_chk(ofs[i], rst[i]); // Reset image
		chk1(irq, 1'b0); // Quiet line
		$display("test reset_values done");

		for (int i = 0; i < 4; i++) begin
			rnd();
			a = OFS_THR_AD + 8'(i);
			wr(a, r);
			rd_chk(a, r);
			chk8(8'({thr_a_d, thr_d_b, thr_b_c, thr_c_mic} >> (24 - 8 * i)), r);
		end
		wr(OFS_JACK_STS, 8'hff);
		rd_chk(OFS_JACK_STS, 8'h00); // Read only
		rnd();
		wr(OFS_JACK_MASK, r);
		ma = r & JACK_FLAG_MASK;
		rd_chk(OFS_JACK_MASK, ma); // Mask layout
		wr(OFS_JACK_MASK, 8'h00);
		ma = 8'h00;
		rnd();
		wr(OFS_HPTEST, r);
		rd_chk(OFS_HPTEST, {3'h0, hptest_comp, 1'b0, r[2:0]});
		chk8({5'h0, hptest_ctrl}, {5'h0, r[2:0]});
		$display("test register_access done");

		wr(OFS_CFG_MAIN, 8'hd3);
		#1 chk8(cfg_main, 8'hd3); // Enable and interval
		jack(1'b1);
		wait_pulse(1'b0, 20);
		chk1(kind_detect_req, 1'b1); // Detect request
		ea = 8'h01;
		rd_chk(OFS_JACK_EVT, ea); // Insert flag
		rnd();
		@(posedge ref_clk);
		detect_done    <= 1'b1;
		detected_kind  <= 1'b1;
		detected_order <= r[0];
		@(posedge ref_clk);
		detect_done <= 1'b0;
		ea = 8'h05;
		st = {4'h0, 1'b1, r[0], 2'b11};
		rd_chk(OFS_JACK_EVT, ea); // Done flag
		rd_chk(OFS_JACK_STS, st); // Jack status
		chk1(micbias_en, 1'b1); // Supply on
		chk1(irq, exp_irq()); // Raised
		wr(OFS_JACK_MASK, 8'h07);
		ma = 8'h07;
		step(2);
		chk1(irq, exp_irq()); // Masked
		wr(OFS_JACK_EVT, 8'h00);
		rd_chk(OFS_JACK_EVT, ea); // Zero
		wr(OFS_JACK_EVT, 8'h01);
		ea = 8'h04;
		rd_chk(OFS_JACK_EVT, ea); // One clears
		wr(OFS_JACK_MASK, 8'h00);
		ma = 8'h00;
		wr(OFS_JACK_EVT, 8'h07);
		ea = 8'h00;
		$display("test insertion done");

		wait_pulse(1'b1, 300);
		wait_pulse(1'b1, 300);
		chk8(8'(n), 8'd20); // Two ms period
		$display("test interval done");

		for (int i = 0; i < 6; i++) begin
			rnd();
			@(posedge ref_clk);
			button_press      <= r[3:0];
			button_release    <= r[7:4];
			button_code_valid <= 1'b1;
			button_code       <= seed[15:8];
			@(posedge ref_clk);
			{button_press, button_release, button_code_valid} <= 9'h0;
			eb |= {r[4], r[5], r[6], r[7], r[3:0]};
			code = seed[15:8];
			rd_chk(OFS_BTN_EVT, eb); // Button flags
			rd_chk(OFS_BTN_STS, code); // Last code
			rnd();
			wr(OFS_BTN_MASK, r);
			mb = r;
			step(2);
			chk1(irq, exp_irq()); // Button masks
			rnd();
			wr(OFS_BTN_EVT, r);
			eb &= ~r;
			rd_chk(OFS_BTN_EVT, eb); // Partial clear
		end
		wr(OFS_BTN_MASK, 8'h00);
		mb = 8'h00;
		wr(OFS_BTN_EVT, 8'hff);
		eb = 8'h00;
		$display("test buttons done");

		wr(OFS_CFG_TIMING, CFG_TIMING_RST | 8'h01);
		#1 chk8(cfg_timing, CFG_TIMING_RST | 8'h01); // Pause bit
		step(2);
		@(posedge ref_clk);
		button_press <= 4'hf;
		@(posedge ref_clk);
		button_press <= 4'h0;
		rd_chk(OFS_BTN_EVT, eb); // Paused
		r = 8'h00;
		repeat (60) begin
			@(posedge ref_clk);
			#1 r += 8'(button_measure_req);
		end
		chk8(r, 8'h00); // No measuring
		jack(1'b0);
		step(3);
		ea = 8'h02;
		rd_chk(OFS_JACK_EVT, ea); // Removal seen
		rd_chk(OFS_JACK_STS, 8'h00); // Absent
		chk1(micbias_en, 1'b0); // Supply off
		wr(OFS_JACK_EVT, 8'hff);
		ea = 8'h00;
		wr(OFS_CFG_TIMING, CFG_TIMING_RST);
		$display("test pause done");

		wr(OFS_FORCE_AVG, 8'hf1);
		rd_chk(OFS_FORCE_AVG, 8'h31); // Forced fields
		chk8(force_avg, 8'h31); // Forced fields
		wr(OFS_CFG_MAIN, 8'h13);
		jack(1'b1);
		step(3);
		ea = 8'h05;
		rd_chk(OFS_JACK_EVT, ea); // Forced done
		rd_chk(OFS_JACK_STS, 8'h0f); // Forced kind
		wr(OFS_JACK_EVT, 8'hff);
		ea = 8'h00;
		$display("test forced done");

		wr(OFS_CFG_MAIN, 8'h12);
		rd_chk(OFS_JACK_STS, 8'h00); // Disabled clear
		jack(1'b0);
		step(3);
		jack(1'b1);
		step(3);
		rd_chk(OFS_JACK_EVT, 8'h00); // No events
		chk1(irq, 1'b0); // Stays low
		$display("test disable done");
		summarize();
	end
endmodule : test_accessory_detect_status_irq
`default_nettype wire
